/* File: shared/udc_pkg.sv */
// Constants and types of the DMA request and mode engine.
// Assumes: 32-bit APB slave and a 32-bit memory master port.
package udc_pkg;
  localparam int NCH = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_ENA_SET  = 8'h00;
  localparam logic [7:0] OFF_ENA_CLR  = 8'h04;
  localparam logic [7:0] OFF_BURST_SET = 8'h08;
  localparam logic [7:0] OFF_BURST_CLR = 8'h0C;
  localparam logic [7:0] OFF_PRIO_SET = 8'h10;
  localparam logic [7:0] OFF_PRIO_CLR = 8'h14;
  localparam logic [7:0] OFF_TBL_BASE = 8'h18;
  localparam logic [7:0] OFF_ALT_STAT = 8'h1C;
  localparam logic [7:0] OFF_STATUS   = 8'h20;
  localparam logic [31:0] VEC_RST     = 32'h0000_0000;
  // Control table layout
  localparam logic [9:0] ALT_HALF     = 10'h200;
  localparam int         SLOT_SHIFT   = 4;
  localparam logic [3:0] CS_SRC       = 4'h0;
  localparam logic [3:0] CS_DST       = 4'h4;
  localparam logic [3:0] CS_CTL       = 4'h8;
  localparam int         TBL_ALIGN    = 10;
  // Control word fields
  localparam int MODE_LSB  = 0;
  localparam int BONLY_BIT = 3;
  localparam int CNT_LSB   = 4;
  localparam int CNT_W     = 11;
  localparam int ARB_LSB   = 15;
  localparam int SSIZE_LSB = 24;
  localparam int SINC_LSB  = 26;
  localparam int DSIZE_LSB = 28;
  localparam int DINC_LSB  = 30;
  localparam logic [3:0] ARB_POW_MAX = 4'hA;
  localparam logic [1:0] INC_NONE    = 2'h3;
  typedef enum logic [2:0] {
    MODE_STOP = 3'h0,
    MODE_BASIC = 3'h1,
    MODE_AUTO = 3'h2,
    MODE_PINGPONG = 3'h3
  } udc_mode_t;
endpackage : udc_pkg

/* File: shared/udc_arb_if.sv */
// Carries requesting channels to the priority picker and the winner back.
// Assumes: one clock domain, purely combinational picker.
`timescale 1ns/1ns
interface udc_arb_if #(parameter int N = 32);
  logic [N-1:0]         pending;
  logic [N-1:0]         high;
  logic                 win_valid;
  logic [$clog2(N)-1:0] win_idx;
  modport picker (input pending, high, output win_valid, win_idx);
  modport client (output pending, high, input win_valid, win_idx);
endinterface : udc_arb_if

/* File: rtl/udc_arbiter.sv */
// Fixed priority picker: high group first, then lowest channel number.
// Assumes: inputs stable for the cycle in which the winner is used.
`timescale 1ns/1ns
module udc_arbiter
  import udc_pkg::*;
#(parameter int N = 32)
(
  udc_arb_if.picker arb  // Request and winner bundle
);
  function automatic logic [$clog2(N):0] first_set(input logic [N-1:0] v);
    logic [$clog2(N):0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, i[$clog2(N)-1:0]};
      end
    end
    return r;
  endfunction : first_set

  wire [$clog2(N):0] hi_pick  = first_set(arb.pending & arb.high);
  wire [$clog2(N):0] any_pick = first_set(arb.pending);
  wire [$clog2(N):0] pick     = hi_pick[$clog2(N)] ? hi_pick : any_pick; // RQ23
  assign arb.win_valid = pick[$clog2(N)];
  assign arb.win_idx   = pick[$clog2(N)-1:0];
endmodule : udc_arbiter

/* File: rtl/udc_engine.sv */
// DMA request and mode engine: APB registers, arbitration, table walk.
// Assumes: memory port holds mem_ack for one cycle per accepted request.
// Notes on behaviour
// (RQ1) Burst request beats single request on the same channel.
// (RQ2) Single request alone moves one item, then waits.
// (RQ3) Burst moves min(arbitration size, items remaining).
// (RQ4) Burst-only channels ignore single requests; the code serves one in Auto mode when only the control word flag is set.
// (RQ5) Software aligns the control table to 1024 bytes.
// (RQ6) Primary at n*0x10, alternate at 0x200+n*0x10.
// (RQ7) Structure: source end, destination end, control word, unused.
// (RQ8) End pointers are inclusive; fixed sides use them unchanged.
// (RQ9) Control word fields all steer the transfer.
// (RQ10) Count and mode written back; zero and Stop at the end.
// (RQ11) End pointer words are never written back.
// (RQ12) Software rewrites the control word before each transfer.
// (RQ13) Enable set register enables, enable clear register disables.
// (RQ14) Channel disables itself when its whole transfer completes.
// (RQ15) Stop mode moves nothing and disables the channel.
// (RQ16) Basic moves items while items remain and request stands.
// (RQ17) A momentary request in Basic moves just one item.
// (RQ18) Auto runs to completion once a request was seen.
// (RQ19) Ping-Pong alternates primary and alternate structures forever.
// (RQ20) Each Ping-Pong switch pulses the channel interrupt.
// (RQ21) Serial ports raise single and level-4 burst requests.
// (RQ22) USB FIFOs raise only burst requests.
// (RQ23) High priority wins, then lower channel number.
// (RQ24) Arbitration size 1 to 1024, then rearbitrate.
// (RQ25) Disabled channels are ignored entirely.
// (RQ26) Table base register low ten bits read as zero.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
module udc_engine
  import udc_pkg::*;
#(parameter int N = 32)
(
  input  wire logic          pclk,       // System clock
  input  wire logic          presetn,    // Async reset, active low
  input  wire logic [7:0]    paddr,      // APB address
  input  wire logic          psel,       // APB select
  input  wire logic          penable,    // APB enable
  input  wire logic          pwrite,     // APB direction
  input  wire logic [31:0]   pwdata,     // APB write data
  output logic      [31:0]   prdata,     // APB read data
  output logic               pready,     // APB ready
  output logic               pslverr,    // APB error, unmapped address
  input  wire logic [N-1:0]  single_req, // Single requests
  input  wire logic [N-1:0]  burst_req,  // Burst requests
  output logic               mem_req,    // Memory request, held to ack
  output logic               mem_we,     // Memory write
  output logic      [31:0]   mem_addr,   // Memory byte address
  output logic      [1:0]    mem_size,   // 0 byte, 1 half, 2 word
  output logic      [31:0]   mem_wdata,  // Memory write data
  input  wire logic [31:0]   mem_rdata,  // Memory read data
  input  wire logic          mem_ack,    // Memory done
  output logic      [N-1:0]  chan_done   // Completion pulse per channel
);
  localparam int CW = $clog2(N);
  typedef enum {S_IDLE, S_CTL, S_SRC, S_DST, S_RD, S_WR, S_WB} udc_state_t;

  // ***********************************************
  // Register bus
  // ***********************************************
  logic [N-1:0]  ena_reg, burst_only_reg, prio_reg, alt_reg, hw_clr_reg;
  logic [31:TBL_ALIGN] tbl_reg;
  logic [31:0]   prdata_reg;
  logic          pready_reg, pslverr_reg;
  udc_state_t    state_reg;
  logic [CW-1:0] ch_reg;

  wire wr_en = psel & penable & pready_reg & pwrite;
  wire w_ena_set = wr_en && paddr == OFF_ENA_SET;
  wire w_ena_clr = wr_en && paddr == OFF_ENA_CLR;
  wire w_bo_set  = wr_en && paddr == OFF_BURST_SET;
  wire w_bo_clr  = wr_en && paddr == OFF_BURST_CLR;
  wire w_pr_set  = wr_en && paddr == OFF_PRIO_SET;
  wire w_pr_clr  = wr_en && paddr == OFF_PRIO_CLR;
  wire w_tbl     = wr_en && paddr == OFF_TBL_BASE;
  wire [N-1:0] wmask = pwdata[N-1:0];
  logic [31:0] rd_mux;
  logic        rd_err;
  wire [31:0] status_word = {(32 - CW - 1)'(0), state_reg != S_IDLE, ch_reg};

  always_comb begin
    rd_err = 1'b0;
    if (paddr == OFF_ENA_SET || paddr == OFF_ENA_CLR) begin
      rd_mux = 32'(ena_reg);
    end else if (paddr == OFF_BURST_SET || paddr == OFF_BURST_CLR) begin
      rd_mux = 32'(burst_only_reg);
    end else if (paddr == OFF_PRIO_SET || paddr == OFF_PRIO_CLR) begin
      rd_mux = 32'(prio_reg);
    end else if (paddr == OFF_TBL_BASE) begin
      rd_mux = {tbl_reg, 10'h000}; // RQ26
    end else if (paddr == OFF_ALT_STAT) begin
      rd_mux = 32'(alt_reg);
    end else if (paddr == OFF_STATUS) begin
      rd_mux = status_word;
    end else begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b1;
    end
  end

  // No wait state: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel & ~penable;
      prdata_reg  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_reg <= psel & ~penable & rd_err;
    end
  end

  // Software set wins over a same-cycle hardware disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ena_reg        <= VEC_RST;
      burst_only_reg <= VEC_RST;
      prio_reg       <= VEC_RST;
      tbl_reg        <= '0;
    end else begin
      ena_reg <= (ena_reg & ~hw_clr_reg & ~(w_ena_clr ? wmask : '0))
                 | (w_ena_set ? wmask : '0); // RQ13
      burst_only_reg <= (burst_only_reg & ~(w_bo_clr ? wmask : '0))
                        | (w_bo_set ? wmask : '0);
      prio_reg <= (prio_reg & ~(w_pr_clr ? wmask : '0)) | (w_pr_set ? wmask : '0);
      if (w_tbl) begin
        tbl_reg <= pwdata[31:TBL_ALIGN]; // RQ26
      end
    end
  end

  // ***********************************************
  // Arbitration
  // ***********************************************
  logic [N-1:0] auto_run_reg;
  udc_arb_if #(.N(N)) arb ();
  wire [N-1:0] single_ok = single_req & ~burst_only_reg; // RQ4
  assign arb.pending = ena_reg & ~hw_clr_reg
                       & (burst_req | single_ok | auto_run_reg); // RQ25
  assign arb.high    = prio_reg;
  udc_arbiter #(.N(N)) u_arb (.arb(arb));

  // ***********************************************
  // Transfer engine
  // ***********************************************
  logic [31:0]      ctl_reg, src_end_reg, dst_end_reg, data_reg;
  logic [CNT_W-1:0] rem_reg, burst_left_reg;
  logic             took_burst_reg;

  function automatic logic [31:0] item_addr(input logic [31:0] e,
                                            input logic [CNT_W-1:0] r,
                                            input logic [1:0] inc);
    logic [31:0] back;
    back = 32'(r - CNT_W'(1)) << inc;
    return (inc == INC_NONE) ? e : e - back; // RQ8
  endfunction : item_addr

  wire [CW:0] slot = {alt_reg[ch_reg], ch_reg};
  wire [31:0] ctl_addr = {tbl_reg, 10'(slot) << SLOT_SHIFT} | 32'(CS_CTL); // RQ6 RQ7
  wire [31:0] pick_base = {tbl_reg, 10'(arb.win_idx) << SLOT_SHIFT}
                          | (alt_reg[arb.win_idx] ? 32'(ALT_HALF) : 32'h0000_0000);
  wire [31:0] rd_ctl = mem_rdata;
  udc_mode_t  ctl_mode;
  assign ctl_mode = udc_mode_t'(ctl_reg[MODE_LSB +: 3]);
  wire udc_mode_t rd_mode = udc_mode_t'(rd_ctl[MODE_LSB +: 3]);
  wire [CNT_W-1:0] rd_cnt = rd_ctl[CNT_LSB +: CNT_W];
  wire [3:0] rd_pow = (rd_ctl[ARB_LSB +: 4] > ARB_POW_MAX) ? ARB_POW_MAX
                                                           : rd_ctl[ARB_LSB +: 4];
  wire [CNT_W-1:0] rd_arb = CNT_W'(1) << rd_pow; // RQ24
  wire [CNT_W-1:0] rd_chunk = (rd_arb < rd_cnt) ? rd_arb : rd_cnt; // RQ3
  wire rd_is_auto = rd_mode == MODE_AUTO;
  wire single_blocked = (burst_only_reg[ch_reg] | rd_ctl[BONLY_BIT])
                        & ~took_burst_reg & ~rd_is_auto; // RQ4
  wire [CNT_W-1:0] rem_dec = rem_reg - CNT_W'(1);
  wire [CNT_W-1:0] left_dec = burst_left_reg - CNT_W'(1);
  wire keep_req = (ctl_mode == MODE_AUTO) | (took_burst_reg & burst_req[ch_reg]);
  wire more = rem_dec != '0 && left_dec != '0 && keep_req; // RQ16 RQ17 RQ18
  wire is_pp = ctl_mode == MODE_PINGPONG;
  wire [31:0] wb_word = {ctl_reg[31:CNT_LSB + CNT_W], rem_reg, ctl_reg[BONLY_BIT],
                         rem_reg == '0 ? MODE_STOP : ctl_mode}; // RQ10
  wire [1:0] src_sz = ctl_reg[SSIZE_LSB +: 2];
  wire [1:0] dst_sz = ctl_reg[DSIZE_LSB +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      ch_reg <= '0;
      took_burst_reg <= 1'b0;
      ctl_reg <= 32'h0000_0000;
      src_end_reg <= 32'h0000_0000;
      dst_end_reg <= 32'h0000_0000;
      data_reg <= 32'h0000_0000;
      rem_reg <= '0;
      burst_left_reg <= '0;
      alt_reg <= VEC_RST;
      auto_run_reg <= VEC_RST;
      hw_clr_reg <= VEC_RST;
      chan_done <= VEC_RST;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_size <= 2'h2;
      mem_wdata <= 32'h0000_0000;
    end else begin
      hw_clr_reg <= '0;
      chan_done <= '0;
      if (mem_ack) begin
        mem_req <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (arb.win_valid) begin
            ch_reg <= arb.win_idx;
            took_burst_reg <= burst_req[arb.win_idx]; // RQ1
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= 2'h2;
            mem_addr <= pick_base | 32'(CS_CTL);
            state_reg <= S_CTL;
          end
        end
        S_CTL: begin
          if (mem_ack) begin
            ctl_reg <= rd_ctl;
            if (rd_mode == MODE_STOP || rd_cnt == '0) begin
              hw_clr_reg[ch_reg] <= 1'b1; // RQ15
              auto_run_reg[ch_reg] <= 1'b0;
              state_reg <= S_IDLE;
            end else if (single_blocked && !auto_run_reg[ch_reg]) begin
              state_reg <= S_IDLE;
            end else begin
              rem_reg <= rd_cnt;
              burst_left_reg <= (took_burst_reg | rd_is_auto) ? rd_chunk
                                                               : CNT_W'(1); // RQ2 RQ9
              mem_req <= 1'b1;
              mem_addr <= ctl_addr - 32'(CS_CTL) + 32'(CS_SRC);
              state_reg <= S_SRC;
            end
          end
        end
        S_SRC: begin
          if (mem_ack) begin
            src_end_reg <= mem_rdata;
            mem_req <= 1'b1;
            mem_addr <= ctl_addr - 32'(CS_CTL) + 32'(CS_DST);
            state_reg <= S_DST;
          end
        end
        S_DST: begin
          if (mem_ack) begin
            dst_end_reg <= mem_rdata;
            mem_req <= 1'b1;
            mem_size <= src_sz;
            mem_addr <= item_addr(src_end_reg, rem_reg, ctl_reg[SINC_LSB +: 2]);
            state_reg <= S_RD;
          end
        end
        S_RD: begin
          if (mem_ack) begin
            data_reg <= mem_rdata;
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_size <= dst_sz;
            mem_wdata <= mem_rdata;
            mem_addr <= item_addr(dst_end_reg, rem_reg, ctl_reg[DINC_LSB +: 2]);
            state_reg <= S_WR;
          end
        end
        S_WR: begin
          if (mem_ack) begin
            rem_reg <= rem_dec;
            burst_left_reg <= left_dec;
            if (more) begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_size <= src_sz;
              mem_addr <= item_addr(src_end_reg, rem_dec, ctl_reg[SINC_LSB +: 2]);
              state_reg <= S_RD;
            end else begin
              // Write-back request waits one cycle so it carries the updated count
              mem_size <= 2'h2;
              mem_addr <= ctl_addr;
              state_reg <= S_WB;
            end
          end
        end
        S_WB: begin
          // Only the control word goes back; end pointers are left intact
          if (!mem_req && mem_we) begin
            mem_wdata <= wb_word;
            mem_req <= 1'b1;
          end
          if (mem_ack && mem_addr == ctl_addr && mem_wdata == wb_word) begin
            mem_we <= 1'b0;
            state_reg <= S_IDLE;
            auto_run_reg[ch_reg] <= (rem_reg != '0) && (ctl_mode == MODE_AUTO);
            if (rem_reg == '0) begin
              chan_done[ch_reg] <= 1'b1; // RQ20
              if (is_pp) begin
                alt_reg[ch_reg] <= ~alt_reg[ch_reg]; // RQ19
              end else begin
                hw_clr_reg[ch_reg] <= 1'b1; // RQ14
              end
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ***********************************************
  // Assertions
  // ***********************************************
  sequence ctl_stop_s;
    state_reg == S_CTL && mem_ack && rd_mode == MODE_STOP;
  endsequence
  sequence wb_done_s;
    state_reg == S_WB && mem_ack && rem_reg == '0 && !is_pp;
  endsequence

  burst_pref_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    state_reg == S_IDLE && arb.win_valid && burst_req[arb.win_idx]
    |=> took_burst_reg) else $error("burst request not preferred");
  single_one_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    state_reg == S_WR && mem_ack && !took_burst_reg && ctl_mode != MODE_AUTO
    |=> state_reg == S_WB) else $error("single request moved more than one");
  burst_len_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    state_reg == S_CTL && mem_ack && took_burst_reg && rd_mode != MODE_STOP
    && rd_cnt != '0 && !single_blocked |=> burst_left_reg == $past(rd_chunk))
    else $error("burst length wrong");
  burst_only_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    state_reg == S_IDLE && arb.win_valid |-> !(burst_only_reg[arb.win_idx]
    && !burst_req[arb.win_idx] && !auto_run_reg[arb.win_idx]))
    else $error("single request served on burst-only channel");
  stop_dis_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    ctl_stop_s |=> hw_clr_reg[ch_reg] ##1 !ena_reg[$past(ch_reg)] || $past(w_ena_set))
    else $error("stop mode did not disable channel");
  done_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    wb_done_s |=> chan_done[ch_reg] && hw_clr_reg[ch_reg])
    else $error("completion did not disable channel");
  ptr_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    mem_req && mem_we && state_reg == S_WB |-> mem_addr[3:0] == CS_CTL)
    else $error("end pointer written back");
  wb_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    state_reg == S_WB && mem_ack && rem_reg == '0 |->
    mem_wdata[CNT_LSB +: CNT_W] == '0 && mem_wdata[MODE_LSB +: 3] == MODE_STOP)
    else $error("final write-back not zero count and stop");
  off_ena_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ25
    state_reg == S_IDLE && arb.win_valid |-> ena_reg[arb.win_idx])
    else $error("disabled channel fetched");
  pp_swap_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
    state_reg == S_WB && mem_ack && rem_reg == '0 && is_pp
    |=> alt_reg[ch_reg] != $past(alt_reg[ch_reg]))
    else $error("ping-pong did not switch structure");
endmodule : udc_engine

/* File: tb/udc_mem_model.sv */
// Word memory model on the engine's memory port, one ack per request.
// Assumes: addresses below 0x1000; dly sets the wait before each ack.
`timescale 1ns/1ns
module udc_mem_model (
  input  wire logic        clk,   // Clock
  input  wire logic        rst_n, // Reset, active low
  input  wire logic [3:0]  dly,   // Cycles before ack
  input  wire logic        req,   // Request, held to ack
  input  wire logic        we,    // Write
  input  wire logic [31:0] addr,  // Byte address
  input  wire logic [31:0] wdata, // Write data
  output logic      [31:0] rdata, // Read data, valid with ack
  output logic             ack    // One-cycle answer
);
  logic [31:0] ram [0:1023];
  logic [3:0]  wait_cnt;
  // Outside ack the read bus flips each cycle, so stale data never looks valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack      <= 1'b0;
      wait_cnt <= 4'h0;
      rdata    <= 32'h0000_0000;
    end else if (req && !ack && wait_cnt >= dly) begin
      ack      <= 1'b1;
      wait_cnt <= 4'h0;
      rdata    <= ram[addr[11:2]];
      if (we) ram[addr[11:2]] <= wdata;
    end else begin
      ack   <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack) wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : udc_mem_model

/* File: tb/tb_udc_engine.sv */
// Bench for the DMA request and mode engine: APB tasks and scenarios.
// Assumes: udc_mem_model answers the memory port; table kept at 0x400.
`timescale 1ns/1ns
module tb_udc_engine;
  import udc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, mem_addr, mem_wdata, mem_rdata, chan_done, rd, first;
  logic [31:0] sreq = 0, breq = 0;
  logic        mem_req, mem_we, mem_ack, err;
  logic [1:0]  mem_size;
  logic [3:0]  dly = 0;
  int          mismatches = 0, checks = 0, dones = 0;
  localparam logic [31:0] TB = 32'h0000_0400;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (chan_done !== 0) begin
    if (dones == 0) first = chan_done;
    dones++;
  end
  udc_engine #(.N(NCH)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .single_req(sreq), .burst_req(breq), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .chan_done(chan_done));
  udc_mem_model MEM (.clk(pclk), .rst_n(presetn), .dly(dly), .req(mem_req), .we(mem_we),
    .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] pat(input int i);
    pat = 32'h5A5A_0000 ^ 32'(i);
  endfunction : pat
  function automatic logic [31:0] cw(input logic [2:0] m, input logic [10:0] n,
      input logic [3:0] a, input logic [1:0] si, input logic [1:0] di);
    cw = (32'(m) << MODE_LSB) | (32'(n) << CNT_LSB) | (32'(a) << ARB_LSB) | (32'h2 << SSIZE_LSB)
       | (32'(si) << SINC_LSB) | (32'h2 << DSIZE_LSB) | (32'(di) << DINC_LSB);
  endfunction : cw
  function automatic int wi(input int ch, input int alt);
    wi = (TB + alt * 32'h0000_0200 + ch * 16) / 4;
  endfunction : wi
  task automatic st(input int ch, input int alt, input int s, input int d, input logic [31:0] c);
    MEM.ram[wi(ch, alt)]     = s;
    MEM.ram[wi(ch, alt) + 1] = d;
    MEM.ram[wi(ch, alt) + 2] = c;
  endtask : st
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic tmo();
    mismatches++;
    $display("ERROR %0t: wait ran out", $time);
    conclude();
  endtask : tmo
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) tmo();
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle();
    int q, i;
    q = 0;
    for (i = 0; i < 3000 && q < 20; i++) begin
      @(posedge pclk);
      q = (mem_req === 1'b1) ? 0 : q + 1;
    end
    if (q < 20) tmo();
  endtask : settle
  // Hold requests until: 0 first memory request, 1 control write-back, 2 two
  // completions, 3 fifty-one cycles where nothing is expected to move
  task automatic serve(input logic [31:0] s, input logic [31:0] b, input int ch, input int k);
    int i;
    sreq <= s;
    breq <= b;
    for (i = 0; i < 3000; i++) begin
      @(posedge pclk);
      if (k == 0 && mem_req === 1'b1) break;
      if (k == 1 && mem_req === 1'b1 && mem_we === 1'b1 && mem_addr === 4 * wi(ch, 0) + 8) break;
      if (k == 2 && dones >= 2) break;
      if (k == 3 && i == 50) break;
    end
    if (i >= 3000) tmo();
    if (k == 1) chk(32'(mem_size), 32'h0000_0002);
    sreq <= 32'h0000_0000;
    breq <= 32'h0000_0000;
    settle();
  endtask : serve
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    for (int i = 0; i < 1024; i++) MEM.ram[i] = pat(i);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(OFF_ENA_SET, 1'b0, 0);
    chk(rd, 32'h0000_0000);
    apb(8'h40, 1'b1, 1);
    chk({31'h0, err}, 32'h0000_0001);
    apb(OFF_TBL_BASE, 1'b1, 32'hFFFF_FFFF);
    apb(OFF_TBL_BASE, 1'b0, 0);
    chk(rd, 32'hFFFF_FC00);
    apb(OFF_TBL_BASE, 1'b1, TB);
    // Auto, fixed source, momentary request, two-item arbitration
    st(30, 0, 32'h0000_0800, 32'h0000_090C, cw(MODE_AUTO, 4, 1, INC_NONE, 2));
    apb(OFF_ENA_SET, 1'b1, 32'h4000_0000);
    dones = 0;
    serve(32'h4000_0000, 0, 30, 0);
    for (int i = 0; i < 4; i++) chk(MEM.ram[32'h240 + i], pat(32'h200));
    chk(MEM.ram[wi(30, 0) + 2], cw(MODE_STOP, 0, 1, INC_NONE, 2));
    chk(MEM.ram[wi(30, 0)], 32'h0000_0800);
    apb(OFF_ENA_SET, 1'b0, 0);
    chk(rd & 32'h4000_0000, 0);
    chk(dones, 1);
    // Basic, momentary single request moves one item
    dly = 4'h3;
    st(5, 0, 32'h0000_0A08, 32'h0000_0B08, cw(MODE_BASIC, 3, 0, 2, 2));
    apb(OFF_ENA_SET, 1'b1, 32'h0000_0020);
    serve(32'h0000_0020, 0, 5, 0);
    chk(MEM.ram[32'h2C0], pat(32'h280));
    chk(MEM.ram[32'h2C1], pat(32'h2C1));
    chk(MEM.ram[wi(5, 0) + 2], cw(MODE_BASIC, 2, 0, 2, 2));
    // Burst-only channel ignores single, takes burst
    apb(OFF_BURST_SET, 1'b1, 32'h0000_0020);
    serve(32'h0000_0020, 0, 5, 3);
    chk(MEM.ram[32'h2C1], pat(32'h2C1));
    chk(MEM.ram[wi(5, 0) + 2], cw(MODE_BASIC, 2, 0, 2, 2));
    serve(0, 32'h0000_0020, 5, 1);
    chk(MEM.ram[32'h2C1], pat(32'h281));
    // Burst beats single, then burst limited by items remaining
    dly = 4'h0;
    st(9, 0, 32'h0000_0C14, 32'h0000_0D14, cw(MODE_BASIC, 6, 2, 2, 2));
    apb(OFF_ENA_SET, 1'b1, 32'h0000_0200);
    serve(32'h0000_0200, 32'h0000_0200, 9, 1);
    chk(MEM.ram[wi(9, 0) + 2], cw(MODE_BASIC, 2, 2, 2, 2));
    serve(0, 32'h0000_0200, 9, 1);
    chk(MEM.ram[wi(9, 0) + 2], cw(MODE_STOP, 0, 2, 2, 2));
    chk(MEM.ram[32'h345], pat(32'h305));
    apb(OFF_ENA_SET, 1'b0, 0);
    chk(rd & 32'h0000_0200, 0);
    // Stop mode disables; cleared channel ignores requests
    st(6, 0, 32'h0000_0A48, 32'h0000_0B48, cw(MODE_STOP, 2, 0, 2, 2));
    st(12, 0, 32'h0000_0A88, 32'h0000_0B88, cw(MODE_BASIC, 2, 0, 2, 2));
    apb(OFF_ENA_SET, 1'b1, 32'h0000_1040);
    apb(OFF_ENA_CLR, 1'b1, 32'h0000_1000);
    serve(32'h0000_1040, 0, 6, 3);
    apb(OFF_ENA_SET, 1'b0, 0);
    chk(rd & 32'h0000_1040, 0);
    chk(MEM.ram[32'h2D1], pat(32'h2D1));
    chk(MEM.ram[32'h2E1], pat(32'h2E1));
    chk(MEM.ram[wi(12, 0) + 2], cw(MODE_BASIC, 2, 0, 2, 2));
    // Burst-only flag in the control word also blocks single requests in Basic mode
    st(12, 0, 32'h0000_0A88, 32'h0000_0B88, cw(MODE_BASIC, 2, 0, 2, 2) | 32'h0000_0008);
    apb(OFF_ENA_SET, 1'b1, 32'h0000_1000);
    serve(32'h0000_1000, 0, 12, 3);
    chk(MEM.ram[32'h2E1], pat(32'h2E1));
    chk(MEM.ram[wi(12, 0) + 2], cw(MODE_BASIC, 2, 0, 2, 2) | 32'h0000_0008);
    // High priority bit beats lower channel number
    dly = 4'h2;
    st(2, 0, 32'h0000_0A90, 32'h0000_0B90, cw(MODE_AUTO, 1, 0, 2, 2));
    st(3, 0, 32'h0000_0A94, 32'h0000_0B94, cw(MODE_AUTO, 1, 0, 2, 2));
    apb(OFF_PRIO_SET, 1'b1, 32'h0000_0008);
    apb(OFF_ENA_SET, 1'b1, 32'h0000_000C);
    dones = 0;
    serve(32'h0000_000C, 0, 2, 1);
    chk(first, 32'h0000_0008);
    chk(dones, 2);
    // Ping-pong: primary then alternate, level-4 burst each half
    dly = 4'h1;
    st(7, 0, 32'h0000_0E0C, 32'h0000_0E4C, cw(MODE_PINGPONG, 4, 2, 2, 2));
    st(7, 1, 32'h0000_0E1C, 32'h0000_0E5C, cw(MODE_PINGPONG, 4, 2, 2, 2));
    apb(OFF_ENA_SET, 1'b1, 32'h0000_0080);
    dones = 0;
    serve(0, 32'h0000_0080, 7, 2);
    chk(dones, 2);
    chk(MEM.ram[32'h393], pat(32'h383));
    chk(MEM.ram[32'h397], pat(32'h387));
    chk(MEM.ram[wi(7, 1) + 2], cw(MODE_STOP, 0, 2, 2, 2));
    conclude();
  end
endmodule : tb_udc_engine
